// file: shared/isb_defines.svh
// How it works
// - set bit 7 on operating mode change
// - set bit 6 after miss_max missing cycles (two at reset) with the main reference invalid
// - no failure flag in free-run/holdover
// - bits 5..0 flag inputs 14..9 validity changes
// - flags latch until software writes one
// - byte is status bits 15..8, reset 0x3F
`ifndef ISB_DEFINES_SVH
`define ISB_DEFINES_SVH
`define ISB_ADR_STATUS    4'h0
`define ISB_ADR_LIVE      4'h4
`define ISB_ADR_MISS_MAX  4'h8
`define ISB_STATUS_RESET  8'h3F
`define ISB_BIT_MODE      7
`define ISB_BIT_MAINFAIL  6
`define ISB_MISS_DEFAULT  8'h02
`endif

// file: shared/isb_pkg.sv
`default_nettype none
package isb_pkg;
  typedef enum logic [1:0] {
    ISB_MODE_FREE_RUN = 2'b00,
    ISB_MODE_LOCKED   = 2'b01,
    ISB_MODE_HOLDOVER = 2'b10,
    ISB_MODE_ACQUIRE  = 2'b11
  } isb_mode_t;
endpackage
`default_nettype wire

// file: hw/isb_miss_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "isb_defines.svh"
// counts consecutive reference periods without an edge on the selected reference
module isb_miss_detect
  import isb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ref_edge,
  input  wire logic       period_tick,
  input  wire logic [7:0] miss_max,
  output logic            fail_pulse
);
  logic [7:0] miss_count;
  logic       seen;

  // an edge anywhere in a period clears the run of missing cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      miss_count <= 8'h00;
      seen       <= 1'b0;
      fail_pulse <= 1'b0;
    end else begin
      fail_pulse <= 1'b0;
      if (period_tick) begin
        seen <= 1'b0;
        if (seen || ref_edge) begin
          miss_count <= 8'h00;
        end else if (miss_count != 8'hFF) begin
          miss_count <= miss_count + 8'h01;
          fail_pulse <= (miss_count + 8'h01 == miss_max);
        end
      end else if (ref_edge) begin
        seen <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: hw/isb_status_mid.sv
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "isb_defines.svh"
// middle byte of the latched status word, as seen by software:
//   0x0 status flags, read; write ones to clear
//   0x4 live levels, read only: main reference valid, zero, inputs 14..9
//   0x8 silent periods before the main path counts as failed
// every access is answered one cycle after it is taken, whatever its address,
// so the master never waits on an unmapped hole
// the flags are preset at reset so software starts by seeing every input as
// changed; it is expected to read once and clear before trusting them
// a flag that is set again in the very cycle of its clear survives, at the
// cost of one extra interrupt, rather than losing the event
module isb_status_mid
  import isb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] wb_adr_i,
  input  wire logic [7:0] wb_dat_i,
  input  wire logic       wb_we_i,
  input  wire logic       wb_sel_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  output logic      [7:0] wb_dat_o,
  output logic            wb_ack_o,
  input  wire isb_mode_t  primary_timing_path_mode,
  input  wire logic       main_ref_edge,
  input  wire logic       main_ref_period_tick,
  input  wire logic       main_ref_valid,
  input  wire logic [5:0] ref_valid,
  output logic      [7:0] status_mirror
);
  // the status byte itself, bit 7 down to bit 0
  logic [7:0] interrupt_status_middle;
  logic [7:0] next_status;
  // programmable count of silent periods before the main path is called failed
  logic [7:0] miss_max;
  logic [7:0] next_miss_max;
  // previous input levels for change detection
  isb_mode_t  mode_q;
  logic [5:0] valid_q;
  // event sources
  logic       fail_pulse;
  logic       fail_allowed;
  logic       mode_changed;
  logic [5:0] valid_changed;
  logic [7:0] event_set;
  // bus decode
  logic       bus_req;
  logic       wr_req;
  logic       rd_req;
  logic       hit_status;
  logic       hit_live;
  logic       hit_miss_max;
  logic       wr_status;
  logic       wr_miss_max;
  logic [7:0] w1c_mask;
  logic       next_ack;
  logic [7:0] live_view;
  logic [7:0] next_dat;
  genvar      gi;

  // missing-cycle counter for the reference selected by the main loop
  isb_miss_detect u_miss (
    .clk         (clk),
    .nrst        (nrst),
    .ref_edge    (main_ref_edge),
    .period_tick (main_ref_period_tick),
    .miss_max    (miss_max),
    .fail_pulse  (fail_pulse)
  );

  // previous mode; reset to the idle level so nothing fires at start, while a
  // non-idle level at release does raise its flag once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= ISB_MODE_FREE_RUN;
    end else begin
      mode_q <= primary_timing_path_mode;
    end
  end

  // reference validity history, one bit per input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      valid_q <= 6'h00;
    end else begin
      valid_q <= ref_valid;
    end
  end

  // bit 5 is input fourteen down to bit 0 input nine; either direction counts
  generate
    for (gi = 0; gi < 6; gi++) begin : g_ref
      assign valid_changed[gi] = ref_valid[gi] ^ valid_q[gi];
    end
  endgenerate

  // any step of the operating mode, a step back to free-run included
  assign mode_changed = (primary_timing_path_mode != mode_q);

  // the loop only watches its reference while it is tracking one; in free-run
  // and holdover a silent reference is expected and must stay quiet
  always_comb begin
    unique case (primary_timing_path_mode)
      ISB_MODE_FREE_RUN: fail_allowed = 1'b0;
      ISB_MODE_LOCKED:   fail_allowed = 1'b1;
      ISB_MODE_HOLDOVER: fail_allowed = 1'b0;
      ISB_MODE_ACQUIRE:  fail_allowed = 1'b1;
    endcase
  end

  // gather the events; a still-valid reference never raises the failure flag,
  // but a flag already raised is left for software to clear
  assign event_set[`ISB_BIT_MODE]     = mode_changed;
  assign event_set[`ISB_BIT_MAINFAIL] = fail_pulse && fail_allowed &&
                                        !main_ref_valid;
  assign event_set[5:0]               = valid_changed;

  // classic single-cycle slave: a request is taken while ack is low, so the
  // edge that shows ack never takes the same request twice
  assign bus_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req       = bus_req && wb_we_i && wb_sel_i;
  assign rd_req       = bus_req && !wb_we_i;
  assign hit_status   = (wb_adr_i == `ISB_ADR_STATUS);
  assign hit_live     = (wb_adr_i == `ISB_ADR_LIVE);
  assign hit_miss_max = (wb_adr_i == `ISB_ADR_MISS_MAX);
  assign wr_status    = wr_req && hit_status;
  assign wr_miss_max  = wr_req && hit_miss_max;
  assign next_ack     = bus_req;

  // write-one-to-clear: only ones in the written byte clear flags
  assign w1c_mask = wr_status ? wb_dat_i : 8'h00;

  // a set in the same cycle as its clear wins, so no event is lost
  assign next_status = (interrupt_status_middle & ~w1c_mask) | event_set;

  // sticky flags, preset so software sees every input as changed after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_status_middle <= `ISB_STATUS_RESET;
    end else begin
      interrupt_status_middle <= next_status;
    end
  end

  // a threshold of zero would never fire, so it is held at one
  assign next_miss_max = (wb_dat_i == 8'h00) ? 8'h01 : wb_dat_i;

  // threshold register for the miss detector
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      miss_max <= `ISB_MISS_DEFAULT;
    end else if (wr_miss_max) begin
      miss_max <= next_miss_max;
    end
  end

  // live levels for software that wants the state, not the history
  assign live_view = {main_ref_valid, 1'b0, ref_valid};

  // read mux; unmapped reads return zero but still ack
  always_comb begin
    next_dat = 8'h00;
    if (hit_status) begin
      next_dat = interrupt_status_middle;
    end else if (hit_live) begin
      next_dat = live_view;
    end else if (hit_miss_max) begin
      next_dat = miss_max;
    end
  end

  // ack is a single-cycle pulse; it drops the cycle after it is shown
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= next_ack;
    end
  end

  // read data holds until the next read, so a slow master still sees it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 8'h00;
    end else if (rd_req) begin
      wb_dat_o <= next_dat;
    end
  end

  // registered copy for the upstream interrupt combiner
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_mirror <= `ISB_STATUS_RESET;
    end else begin
      status_mirror <= interrupt_status_middle;
    end
  end
endmodule
`default_nettype wire

// file: tb/isb_status_mid_sva.sv
`timescale 1ns/1ps
`default_nettype none
module isb_status_mid_sva
  import isb_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       wb_we_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic       wb_ack_o,
  input wire isb_mode_t  primary_timing_path_mode,
  input wire logic       main_ref_valid,
  input wire logic [5:0] ref_valid,
  input wire logic [7:0] status_mirror
);
  // any write may clear; the address is left out to keep this cheap
  wire logic wr = wb_cyc_i & wb_stb_i & wb_we_i;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_follow: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_rd_stable: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("dat moved");
  chk_mode_set: assert property (
    $changed(primary_timing_path_mode) |-> ##[1:4] status_mirror[7]) else $error("no mode");
  chk_ref_set: assert property (
    $changed(ref_valid) |-> ##[1:4] (|status_mirror[5:0])) else $error("no ref");
  chk_flag_hold: assert property (
    |($past(status_mirror) & ~status_mirror) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("flag lost");
  chk_fail_gate: assert property ($rose(status_mirror[6]) |-> !$past(main_ref_valid, 2)
    && $past(primary_timing_path_mode, 2) inside {ISB_MODE_LOCKED, ISB_MODE_ACQUIRE})
    else $error("bad fail");
  chk_rst_val: assert property ($rose(nrst) |-> status_mirror == 8'h3F)
    else $error("bad reset");
endmodule
bind isb_status_mid isb_status_mid_sva u_sva (.*);
`default_nettype wire

// file: tb/interrupt_status_mid_byte_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_mid_byte_tb_top
  import isb_pkg::*;
();
  logic       clk, nrst, we, cyc, stb, ack, edg, tick, mv;
  logic [3:0] adr;
  logic [7:0] dat, rdat;
  logic [5:0] rv, n;
  isb_mode_t  mode;
  logic [7:0] q[$];
  int         seed = 86520, error_cnt = 0, total_checks = 0;
  isb_status_mid DUT (.clk(clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_we_i(we),
    .wb_sel_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .primary_timing_path_mode(mode), .main_ref_edge(edg), .main_ref_period_tick(tick),
    .main_ref_valid(mv), .ref_valid(rv), .status_mirror());
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    {adr, dat, we, cyc, stb} <= {a, d, w, 2'b11};
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    q.push_back(e);
    wb(a, 8'h00, 1'b0);
  endtask
  // read status then clear every flag, so each step starts clean
  task automatic ck(input logic [7:0] e);
    repeat (2) @(posedge clk);
    rd(4'h0, e);
    wb(4'h0, 8'hFF, 1'b1);
  endtask
  // the period holding the edge ends at the first tick, then k silent periods
  task automatic tk(input int k);
    @(posedge clk) edg <= 1'b1;
    @(posedge clk) edg <= 1'b0;
    repeat (k + 1) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
    end
  endtask
  // read results are compared in order of issue
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      total_checks++;
      if (rdat !== q.pop_front()) begin
        error_cnt++;
        $display("[ERR] %0t read mismatch", $time);
      end
    end
  end
  initial begin
    {nrst, cyc, stb, we, edg, tick, mv, adr, dat, rv} = '0;
    mode = ISB_MODE_FREE_RUN;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    ck(8'h3F);
    rd(4'hC, 8'h00);
    rd(4'h8, 8'h02);
    ck(8'h00);
    for (int i = 0; i < 8; i++) begin
      n = 6'($random(seed));
      rv <= n;
      ck({2'b00, n ^ rv});
    end
    rd(4'h4, {2'b00, n});
    for (int i = 1; i < 5; i++) begin
      mode <= isb_mode_t'(i[1:0]);
      ck(8'h80);
    end
    mode <= ISB_MODE_HOLDOVER;
    ck(8'h80);
    tk(2);
    ck(8'h00);
    mode <= ISB_MODE_LOCKED;
    ck(8'h80);
    tk(1);
    ck(8'h00);
    tk(2);
    ck(8'h40);
    mv <= 1'b1;
    tk(2);
    ck(8'h00);
    complete_run();
  end
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
